// File: src/adcrs_pkg.sv
/*
  Package of the converter result store: register offsets, field positions,
  reset values and interrupt status layout.
  Assumes an 8-bit register port with a 4-bit byte address.
*/
package adcrs_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RES_W  = 10;

  // register offsets
  localparam logic [3:0] OFS_RES6_LOW   = 4'h0;
  localparam logic [3:0] OFS_RES6_HIGH  = 4'h1;
  localparam logic [3:0] OFS_RES7_LOW   = 4'h2;
  localparam logic [3:0] OFS_RES7_HIGH  = 4'h3;
  localparam logic [3:0] OFS_PRIO_LOW   = 4'h4;
  localparam logic [3:0] OFS_PRIO_HIGH  = 4'h5;
  localparam logic [3:0] OFS_CMP0_LOW   = 4'h6;
  localparam logic [3:0] OFS_CMP0_HIGH  = 4'h7;
  localparam logic [3:0] OFS_MON_CTRL   = 4'h8;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h9;
  localparam logic [3:0] OFS_IRQ_MASK   = 4'hA;

  // lower byte fields
  localparam int unsigned LOW_RES_MSB   = 7;
  localparam int unsigned LOW_RES_LSB   = 6;
  localparam int unsigned LOW_OVR_BIT   = 1;
  localparam int unsigned LOW_STORE_BIT = 0;
  // upper byte holds result bits 9..2
  localparam int unsigned HIGH_RES_MSB  = 9;
  localparam int unsigned HIGH_RES_LSB  = 2;

  // monitor control field
  localparam int unsigned MON_EN_BIT = 0;

  // interrupt status layout: stored flags 0..2, overrun flags 3..5
  localparam int unsigned NUM_SLOTS    = 3;
  localparam int unsigned IRQ_W        = 6;
  localparam int unsigned IRQ_STORE_LSB = 0;
  localparam int unsigned IRQ_OVR_LSB   = 3;

  localparam int unsigned SLOT_RES6 = 0;
  localparam int unsigned SLOT_RES7 = 1;
  localparam int unsigned SLOT_PRIO = 2;

  // reset values
  localparam logic [9:0] RST_RESULT  = 10'h000;
  localparam logic [9:0] RST_COMPARE = 10'h000;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [5:0] RST_IRQ     = 6'h00;
  localparam logic       RST_FLAG    = 1'b0;

endpackage : adcrs_pkg

// File: src/adcrs_slot.sv
/*
  One result slot: 10-bit result, result-stored flag and overrun flag.
  Assumes store and read strobes are single-cycle pulses on sys_clk.
*/
`timescale 1ns/100ps
module adcrs_slot (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       store,
  input  wire logic [9:0] store_data,
  input  wire logic       rd_low,
  input  wire logic       rd_high,
  output logic      [9:0] result_q,
  output logic            stored_q,
  output logic            overrun_q,
  output logic            overrun_evt
);

  logic high_read_q;
  logic unread_q;

  // overwrite before both bytes were read since the last store
  assign overrun_evt = store && unread_q && !(rd_low && (high_read_q || rd_high)); // RL5

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= adcrs_pkg::RST_RESULT;
    end else if (store) begin
      result_q <= store_data;
    end
  end

  // set wins over the clearing read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stored_q <= adcrs_pkg::RST_FLAG;
    end else if (store) begin
      stored_q <= 1'b1; // RL3
    end else if (rd_low) begin
      stored_q <= 1'b0; // RL4
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= adcrs_pkg::RST_FLAG;
    end else if (overrun_evt) begin
      overrun_q <= 1'b1; // RL5
    end else if (rd_low) begin
      overrun_q <= 1'b0; // RL6
    end
  end

  // tracks whether both bytes have been read since the last store
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_read_q <= adcrs_pkg::RST_FLAG;
      unread_q    <= adcrs_pkg::RST_FLAG;
    end else if (store) begin
      high_read_q <= 1'b0;
      unread_q    <= 1'b1;
    end else begin
      if (rd_high) begin
        high_read_q <= 1'b1;
      end
      if (rd_low && (high_read_q || rd_high)) begin
        unread_q <= 1'b0;
      end
    end
  end

endmodule : adcrs_slot

// File: src/adcrs_compare.sv
/*
  Software-writable 10-bit comparison value, written as two bytes.
  Assumes write strobes are single-cycle pulses on sys_clk.
*/
`timescale 1ns/100ps
module adcrs_compare (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       wr_low,
  input  wire logic       wr_high,
  input  wire logic [7:0] wr_data,
  output logic      [9:0] value_q
);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= adcrs_pkg::RST_COMPARE;
    end else begin
      if (wr_high) begin
        value_q[9:2] <= wr_data; // RL8
      end
      if (wr_low) begin
        value_q[1:0] <= wr_data[7:6]; // RL8
      end
    end
  end

endmodule : adcrs_compare

// File: src/adcrs_top.sv
/*
  Converter result store: two normal result slots, one top-priority slot,
  comparison register 0, monitor enable, and a read-cleared interrupt status.
  Assumes the conversion core presents each result as a one-cycle strobe, and
  software uses an 8-bit register port with read data one cycle after the read.
*/
`timescale 1ns/100ps
// Behaviour
// RL1: lower byte bits 7:6 hold result bits 1:0; bits 5:2 read zero.
// RL2: upper byte holds result bits 9:2 of the same slot.
// RL3: storing a result sets that slot's result-stored flag.
// RL4: reading the lower byte clears the slot's result-stored flag.
// RL5: store over a slot not fully read sets its overrun flag.
// RL6: reading the overrun flag clears it; one means overrun happened.
// RL7: software reads upper byte first, then lower byte.
// RL8: comparison pair holds writable 10-bit value, unused lower bits read zero.
// RL9: software changes comparison value only while the monitor is disabled.
// RL10: top-priority results go to their own slot with separate flags.
module adcrs_top (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // conversion core
  input  wire logic       conv_valid,
  input  wire logic [9:0] conv_data,
  input  wire logic       conv_priority,
  input  wire logic       conv_slot_sel,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // to monitor logic, and the masked interrupt request
  output logic      [9:0] compare0_value,
  output logic            monitor_enable_bit,
  output logic            irq
);

  localparam int unsigned N = adcrs_pkg::NUM_SLOTS;

  logic [N-1:0] slot_store;
  logic [N-1:0] slot_rd_low;
  logic [N-1:0] slot_rd_high;
  logic [9:0]   slot_result [N];
  logic [N-1:0] slot_stored;
  logic [N-1:0] slot_overrun;
  logic [N-1:0] slot_ovr_evt;

  logic [5:0]   irq_status_q;
  logic [5:0]   irq_status_d;
  logic [5:0]   irq_mask_q;
  logic [5:0]   irq_events;
  logic         mon_en_q;
  logic [7:0]   rdata_d;
  logic [7:0]   rdata_q;
  logic         cmp_wr_low;
  logic         cmp_wr_high;
  logic         rd_status;

  // route the incoming result to exactly one slot
  always_comb begin
    slot_store = '0;
    if (conv_valid) begin
      if (conv_priority) begin
        slot_store[adcrs_pkg::SLOT_PRIO] = 1'b1; // RL10
      end else if (conv_slot_sel) begin
        slot_store[adcrs_pkg::SLOT_RES7] = 1'b1;
      end else begin
        slot_store[adcrs_pkg::SLOT_RES6] = 1'b1;
      end
    end
  end

  // read side effects per slot
  always_comb begin
    slot_rd_low  = '0;
    slot_rd_high = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        adcrs_pkg::OFS_RES6_LOW:  slot_rd_low[adcrs_pkg::SLOT_RES6]  = 1'b1;
        adcrs_pkg::OFS_RES6_HIGH: slot_rd_high[adcrs_pkg::SLOT_RES6] = 1'b1;
        adcrs_pkg::OFS_RES7_LOW:  slot_rd_low[adcrs_pkg::SLOT_RES7]  = 1'b1;
        adcrs_pkg::OFS_RES7_HIGH: slot_rd_high[adcrs_pkg::SLOT_RES7] = 1'b1;
        adcrs_pkg::OFS_PRIO_LOW:  slot_rd_low[adcrs_pkg::SLOT_PRIO]  = 1'b1;
        adcrs_pkg::OFS_PRIO_HIGH: slot_rd_high[adcrs_pkg::SLOT_PRIO] = 1'b1;
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_slot
      adcrs_slot u_slot (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .store       (slot_store[g]),
        .store_data  (conv_data),
        .rd_low      (slot_rd_low[g]),
        .rd_high     (slot_rd_high[g]),
        .result_q    (slot_result[g]),
        .stored_q    (slot_stored[g]),
        .overrun_q   (slot_overrun[g]),
        .overrun_evt (slot_ovr_evt[g])
      );
    end
  endgenerate

  assign cmp_wr_low  = reg_wr && (reg_addr == adcrs_pkg::OFS_CMP0_LOW);
  assign cmp_wr_high = reg_wr && (reg_addr == adcrs_pkg::OFS_CMP0_HIGH);

  // value is accepted whatever the monitor state; software keeps it stable
  adcrs_compare u_compare (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_low  (cmp_wr_low),
    .wr_high (cmp_wr_high),
    .wr_data (reg_wdata),
    .value_q (compare0_value)
  ); // RL9

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_en_q <= adcrs_pkg::RST_FLAG;
    end else if (reg_wr && (reg_addr == adcrs_pkg::OFS_MON_CTRL)) begin
      mon_en_q <= reg_wdata[adcrs_pkg::MON_EN_BIT];
    end
  end

  assign monitor_enable_bit = mon_en_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= adcrs_pkg::RST_IRQ;
    end else if (reg_wr && (reg_addr == adcrs_pkg::OFS_IRQ_MASK)) begin
      irq_mask_q <= reg_wdata[5:0];
    end
  end

  // sticky events; a read clears, a same-cycle event survives the read
  assign irq_events = {slot_ovr_evt, slot_store};
  assign rd_status  = reg_rd && (reg_addr == adcrs_pkg::OFS_IRQ_STATUS);

  always_comb begin
    irq_status_d = irq_status_q;
    if (rd_status) begin
      irq_status_d = '0;
    end
    irq_status_d = irq_status_d | irq_events;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= adcrs_pkg::RST_IRQ;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // lower byte: result bits 1:0 on 7:6, zeros on 5:2, overrun, stored
  function automatic logic [7:0] adcrs_low_byte(input logic [9:0] res,
                                                input logic       ovr,
                                                input logic       stored);
    adcrs_low_byte = {res[1:0], 4'h0, ovr, stored}; // RL1 RL6
  endfunction : adcrs_low_byte

  // read mux captures the value before any read-clear takes effect
  always_comb begin
    rdata_d = adcrs_pkg::RST_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        adcrs_pkg::OFS_RES6_LOW:
          rdata_d = adcrs_low_byte(slot_result[adcrs_pkg::SLOT_RES6],
                                   slot_overrun[adcrs_pkg::SLOT_RES6],
                                   slot_stored[adcrs_pkg::SLOT_RES6]); // RL1
        adcrs_pkg::OFS_RES6_HIGH:
          rdata_d = slot_result[adcrs_pkg::SLOT_RES6][9:2]; // RL2
        adcrs_pkg::OFS_RES7_LOW:
          rdata_d = adcrs_low_byte(slot_result[adcrs_pkg::SLOT_RES7],
                                   slot_overrun[adcrs_pkg::SLOT_RES7],
                                   slot_stored[adcrs_pkg::SLOT_RES7]); // RL1
        adcrs_pkg::OFS_RES7_HIGH:
          rdata_d = slot_result[adcrs_pkg::SLOT_RES7][9:2]; // RL2
        adcrs_pkg::OFS_PRIO_LOW:
          rdata_d = adcrs_low_byte(slot_result[adcrs_pkg::SLOT_PRIO],
                                   slot_overrun[adcrs_pkg::SLOT_PRIO],
                                   slot_stored[adcrs_pkg::SLOT_PRIO]); // RL10
        adcrs_pkg::OFS_PRIO_HIGH:
          rdata_d = slot_result[adcrs_pkg::SLOT_PRIO][9:2]; // RL2
        adcrs_pkg::OFS_CMP0_LOW:
          rdata_d = {compare0_value[1:0], 6'h00}; // RL8
        adcrs_pkg::OFS_CMP0_HIGH:
          rdata_d = compare0_value[9:2]; // RL8
        adcrs_pkg::OFS_MON_CTRL:
          rdata_d = {7'h00, mon_en_q};
        adcrs_pkg::OFS_IRQ_STATUS:
          rdata_d = {2'h0, irq_status_q};
        adcrs_pkg::OFS_IRQ_MASK:
          rdata_d = {2'h0, irq_mask_q};
        default:
          rdata_d = adcrs_pkg::RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= adcrs_pkg::RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : adcrs_top

// File: dv/adcrs_conv_model.sv
/*
  Conversion core model: one result per deliver call, as a one-cycle strobe.
  Assumes one caller at a time, clocked by sys_clk.
*/
`timescale 1ns/100ps
module adcrs_conv_model (
  input  wire logic       sys_clk,
  output logic            conv_valid,
  output logic      [9:0] conv_data,
  output logic            conv_priority,
  output logic            conv_slot_sel
);
  initial begin
    conv_valid    = 1'b0;
    conv_data     = 10'h000;
    conv_priority = 1'b0;
    conv_slot_sel = 1'b0;
  end
  task automatic deliver(input logic [9:0] d, input logic p, input logic s);
    @(posedge sys_clk);
    conv_valid    <= 1'b1;
    conv_data     <= d;
    conv_priority <= p;
    conv_slot_sel <= s;
    @(posedge sys_clk);
    // stale qualifiers are inverted so nothing leans on a held value
    conv_valid    <= 1'b0;
    conv_data     <= ~d;
    conv_priority <= ~p;
    conv_slot_sel <= ~s;
  endtask : deliver
endmodule : adcrs_conv_model

// File: dv/adcrs_asserts.sv
/*
  Port checker of the result store.
  Assumes binding onto adcrs_top, single sys_clk domain.
*/
`timescale 1ns/100ps
module adcrs_asserts (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       conv_valid,
  input wire logic [9:0] conv_data,
  input wire logic       conv_priority,
  input wire logic       conv_slot_sel,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [9:0] compare0_value,
  input wire logic       monitor_enable_bit,
  input wire logic       irq
);
  logic [3:0] high_a;
  assign high_a = conv_priority ? 4'h5 : {2'b00, conv_slot_sel, 1'b1};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle_zero:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
  a_high_after_store:
    assert property ($past(conv_valid, 2) && !$past(conv_valid) && reg_rd
      && reg_addr == $past(high_a, 2) |=> reg_rdata == $past(conv_data[9:2], 3))
      else $error("upper byte wrong");
  a_flags_read_clear:
    assert property ((reg_rd && reg_addr == 4'h0 && !conv_valid) ##1 !conv_valid
      ##1 (reg_rd && reg_addr == 4'h0 && !conv_valid) |=> reg_rdata[1:0] == 2'b00)
      else $error("flags not cleared");
  a_cmp_high_write:
    assert property (reg_wr && reg_addr == 4'h7 |=> compare0_value[9:2] == $past(reg_wdata))
      else $error("compare upper wrong");
  a_cmp_low_write:
    assert property (reg_wr && reg_addr == 4'h6
      |=> compare0_value[1:0] == $past(reg_wdata[7:6])) else $error("compare lower wrong");
  a_cmp_low_read:
    assert property ($past(reg_rd) && $past(reg_addr) == 4'h6
      |-> reg_rdata == {$past(compare0_value[1:0]), 6'h00}) else $error("compare readback");
  a_monitor_write:
    assert property (reg_wr && reg_addr == 4'h8
      |=> monitor_enable_bit == $past(reg_wdata[0])) else $error("monitor bit wrong");
  a_mask_off_quiet:
    assert property (reg_wr && reg_addr == 4'hA && reg_wdata[5:0] == 6'h00 |=> !irq)
      else $error("irq despite mask");
  c_prio: cover property (conv_valid && conv_priority);
  c_irq: cover property ($rose(irq));
  c_status: cover property (reg_rd && reg_addr == 4'h9);
endmodule : adcrs_asserts
bind adcrs_top adcrs_asserts adcrs_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .conv_valid(conv_valid), .conv_data(conv_data), .conv_priority(conv_priority),
  .conv_slot_sel(conv_slot_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .compare0_value(compare0_value), .monitor_enable_bit(monitor_enable_bit), .irq(irq));

// File: dv/tb_top.sv
/*
  Self-checking bench of the result store.
  Assumes the conversion core model and the bound port checker.
*/
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic       p;
    logic       s;
    logic [9:0] d;
    logic [7:0] hi;
    logic [7:0] lo;
  } adcrs_row_t;
  logic       sys_clk;
  logic       rst_n;
  logic       conv_valid;
  logic [9:0] conv_data;
  logic       conv_priority;
  logic       conv_slot_sel;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [9:0] compare0_value;
  logic       monitor_enable_bit;
  logic       irq;
  logic [7:0] rv;
  logic [3:0] la;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  adcrs_row_t rows [4] = '{'{1'b0, 1'b0, 10'h3FF, 8'hFF, 8'hC1},
                           '{1'b0, 1'b1, 10'h201, 8'h80, 8'h41},
                           '{1'b1, 1'b1, 10'h002, 8'h00, 8'h81},
                           '{1'b0, 1'b0, 10'h155, 8'h55, 8'h41}};
  adcrs_top adcrs_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_priority(conv_priority), .conv_slot_sel(conv_slot_sel),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .compare0_value(compare0_value),
    .monitor_enable_bit(monitor_enable_bit), .irq(irq));
  adcrs_conv_model adcrs_conv_model_i (.sys_clk(sys_clk), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_priority(conv_priority), .conv_slot_sel(conv_slot_sel));
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    rv = reg_rdata;
    chk({2'b00, rv}, {2'b00, exp});
  endtask : rchk
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset
  task automatic put(input logic [9:0] d, input logic p, input logic s);
    adcrs_conv_model_i.deliver(d, p, s);
  endtask : put
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    do_reset();
    for (int i = 0; i < 8; i++) rchk(i[3:0], 8'h00);
    foreach (rows[i]) begin
      put(rows[i].d, rows[i].p, rows[i].s);
      la = rows[i].p ? 4'h4 : {2'b00, rows[i].s, 1'b0};
      rchk(la + 4'h1, rows[i].hi);
      rchk(la, rows[i].lo);
    end
    put(10'h004, 1'b0, 1'b1);
    put(10'h008, 1'b0, 1'b1);
    put(10'h3FC, 1'b1, 1'b0);
    rchk(4'h3, 8'h02);
    rchk(4'h2, 8'h03);
    rchk(4'h2, 8'h00);
    rchk(4'h5, 8'hFF);
    rchk(4'h4, 8'h01);
    // lower byte alone leaves the slot counted as unread
    put(10'h001, 1'b0, 1'b0);
    rchk(4'h0, 8'h41);
    put(10'h001, 1'b0, 1'b0);
    rchk(4'h1, 8'h00);
    rchk(4'h0, 8'h43);
    rchk(4'h0, 8'h40);
    wr(4'h6, 8'hFF);
    wr(4'h7, 8'hA5);
    rchk(4'h6, 8'hC0);
    rchk(4'h7, 8'hA5);
    chk(compare0_value, 10'h297);
    wr(4'h8, 8'h01);
    #1 chk({9'h000, monitor_enable_bit}, 10'h001);
    wr(4'h1, 8'h5A);
    rchk(4'h1, 8'h00);
    wr(4'hF, 8'hFF);
    rchk(4'hF, 8'h00);
    rchk(4'h9, 8'h1F);
    wr(4'hA, 8'h01);
    put(10'h000, 1'b0, 1'b1);
    #1 chk({9'h000, irq}, 10'h000);
    put(10'h000, 1'b0, 1'b0);
    #1 chk({9'h000, irq}, 10'h001);
    rchk(4'h9, 8'h03);
    chk({9'h000, irq}, 10'h000);
    wr(4'hA, 8'h00);
    do_reset();
    rchk(4'h7, 8'h00);
    rchk(4'h0, 8'h00);
    chk({compare0_value[9:1], monitor_enable_bit}, 10'h000);
    report_and_stop();
  end
endmodule : tb_top
